// ===== verilog/cmu_top.sv
// capture/match unit: two time bases and sixteen capture/compare channels
`include "cmu_consts.svh"

module cmu_top #(
  parameter int W  = `CMU_TMR_W,
  parameter int NC = `CMU_NUM_CHAN,
  parameter int NT = `CMU_NUM_TMR
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              stagger_in,
  input  cmu_pkg::cmu_tmr_cfg_t  tmr_cfg_in       [NT],
  input  wire logic [NT-1:0]     tmr_load_in,
  input  wire logic [W-1:0]      tmr_load_val_in  [NT],
  input  wire logic [NT-1:0]     tmr_reload_wr_in,
  input  wire logic [W-1:0]      tmr_reload_val_in[NT],
  input  wire logic              gpt_ovf_in,
  input  wire logic [NT-1:0]     ext_cnt_in,
  input  cmu_pkg::cmu_chan_cfg_t chan_cfg_in      [NC],
  input  wire logic [NC-1:0]     cc_wr_in,
  input  wire logic [W-1:0]      cc_wdata_in      [NC],
  input  wire logic [NC-1:0]     pin_in,
  output logic [NC-1:0]          pin_out,
  output logic [NC-1:0]          pin_oe_n_out,
  output logic [W-1:0]           cc_val_out       [NC],
  output logic [NC-1:0]          irq_out,
  output logic [NC-1:0]          done_out,
  output logic [W-1:0]           tmr_count_out    [NT],
  output logic [NT-1:0]          tmr_ovf_out,
  output logic [W-1:0]           tmr_reload_out   [NT]
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [NT-1:0][W-1:0] reload;
    logic [NC-1:0][W-1:0] value;
    logic [NC-1:0]        pin;
    logic [NC-1:0]        oe_n;
    logic [NC-1:0]        irq;
    logic [NC-1:0]        fired;
    logic [NC-1:0]        done;
  } cmu_top_st_t;

  cmu_top_st_t            st_q;
  cmu_top_st_t            st_d;
  cmu_pkg::cmu_tmr_stat_t tstat [NT];
  logic [NC-1:0]          trig;
  logic [NC-1:0]          match;
  logic [NC-1:0]          t_ovf;
  logic [W-1:0]           t_cnt [NC];

  // --------------------------------------------------------------------
  // decoding used for several channels
  // --------------------------------------------------------------------
  function automatic logic is_cmp(input cmu_pkg::cmu_mode_t m);
    case (m)
      cmu_pkg::CMU_MODE_CMP0: return 1'b1;
      cmu_pkg::CMU_MODE_CMP1: return 1'b1;
      cmu_pkg::CMU_MODE_CMP2: return 1'b1;
      cmu_pkg::CMU_MODE_CMP3: return 1'b1;
      cmu_pkg::CMU_MODE_DBL:  return 1'b1;
      default:                return 1'b0;
    endcase
  endfunction

  function automatic logic drives_pin(input cmu_pkg::cmu_mode_t m);
    case (m)
      cmu_pkg::CMU_MODE_CMP1: return 1'b1;
      cmu_pkg::CMU_MODE_CMP3: return 1'b1;
      cmu_pkg::CMU_MODE_DBL:  return 1'b1;
      default:                return 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // time bases
  // --------------------------------------------------------------------
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    cmu_timer #(
      .W (W)
    ) u_tmr (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .cfg_in        (tmr_cfg_in[t]),
      .stagger_in    (stagger_in),
      .gpt_ovf_in    (gpt_ovf_in),
      .ext_cnt_in    (ext_cnt_in[t]),
      .load_in       (tmr_load_in[t]),
      .load_val_in   (tmr_load_val_in[t]),
      .reload_val_in (st_q.reload[t]),
      .stat_out      (tstat[t])
    );
    assign tmr_count_out[t]  = tstat[t].count;
    assign tmr_ovf_out[t]    = tstat[t].ovf;
    assign tmr_reload_out[t] = st_q.reload[t];
  end

  // --------------------------------------------------------------------
  // per channel timer selection, edge detect and match
  // --------------------------------------------------------------------
  for (genvar c = 0; c < NC; c++) begin : g_chan
    cmu_edge u_edge (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pin_in      (pin_in[c]),
      .sel_in      (chan_cfg_in[c].edge_sel),
      .trig_out    (trig[c])
    );
    assign t_cnt[c] = tstat[chan_cfg_in[c].tmr_sel].count;
    assign t_ovf[c] = tstat[chan_cfg_in[c].tmr_sel].ovf;
    // a match is counted when the timer has just stepped onto the value
    assign match[c] = is_cmp(chan_cfg_in[c].mode)
                    & tstat[chan_cfg_in[c].tmr_sel].tick
                    & (t_cnt[c] == st_q.value[c])
                    & ~st_q.done[c];
    assign cc_val_out[c]   = st_q.value[c];
    assign pin_out[c]      = st_q.pin[c];
    assign pin_oe_n_out[c] = st_q.oe_n[c];
    assign irq_out[c]      = st_q.irq[c];
    assign done_out[c]     = st_q.done[c];
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic dbl_hit;
    logic ev;
    dbl_hit = 1'b0;
    ev      = 1'b0;
    st_d    = st_q;
    st_d.irq = '0;
    for (int t = 0; t < NT; t++) begin
      if (tmr_reload_wr_in[t]) begin
        st_d.reload[t] = tmr_reload_val_in[t];
      end
    end
    for (int c = 0; c < NC; c++) begin
      ev = 1'b0;
      // a register written by software restarts a single event channel
      if (cc_wr_in[c]) begin
        st_d.value[c] = cc_wdata_in[c];
        st_d.done[c]  = 1'b0;
      end
      // the pin is output only while a pin driving compare mode owns it
      st_d.oe_n[c] = ~drives_pin(chan_cfg_in[c].mode);
      // overflow opens a new period for once per period modes
      if (t_ovf[c]) begin
        st_d.fired[c] = 1'b0;
      end
      dbl_hit = 1'b0;
      if (c < `CMU_DBL_OFFSET) begin
        dbl_hit = (chan_cfg_in[c].mode == cmu_pkg::CMU_MODE_DBL)
                & match[(c + `CMU_DBL_OFFSET) % NC];
      end
      case (chan_cfg_in[c].mode)
        cmu_pkg::CMU_MODE_CAP: begin
          if (trig[c]) begin
            st_d.value[c] = t_cnt[c];
            st_d.irq[c]   = 1'b1;
          end
        end
        cmu_pkg::CMU_MODE_CMP0: begin
          if (match[c]) begin
            st_d.irq[c] = 1'b1;
            ev          = 1'b1;
          end
        end
        cmu_pkg::CMU_MODE_CMP1: begin
          if (match[c]) begin
            st_d.pin[c] = ~st_q.pin[c];
            st_d.irq[c] = 1'b1;
            ev          = 1'b1;
          end
        end
        cmu_pkg::CMU_MODE_CMP2: begin
          if (match[c] && !st_q.fired[c]) begin
            st_d.irq[c]   = 1'b1;
            st_d.fired[c] = 1'b1;
            ev            = 1'b1;
          end
        end
        cmu_pkg::CMU_MODE_CMP3: begin
          if (t_ovf[c]) begin
            st_d.pin[c] = 1'b0;
          end
          if (match[c] && !st_q.fired[c]) begin
            st_d.pin[c]   = 1'b1;
            st_d.irq[c]   = 1'b1;
            st_d.fired[c] = 1'b1;
            ev            = 1'b1;
          end
        end
        cmu_pkg::CMU_MODE_DBL: begin
          if (match[c] || dbl_hit) begin
            st_d.pin[c] = ~st_q.pin[c];
            st_d.irq[c] = 1'b1;
            ev          = 1'b1;
          end
        end
        default: begin
          st_d.fired[c] = 1'b0;
        end
      endcase
      // an event in the same cycle as a write still ends the channel
      if (ev && chan_cfg_in[c].single_en) begin
        st_d.done[c] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int t = 0; t < NT; t++) begin
        st_q.reload[t] <= `CMU_RST_RELOAD;
      end
      for (int c = 0; c < NC; c++) begin
        st_q.value[c] <= `CMU_RST_VALUE;
        st_q.pin[c]   <= `CMU_RST_PIN;
        st_q.oe_n[c]  <= `CMU_RST_OE_N;
      end
      st_q.irq   <= '0;
      st_q.fired <= '0;
      st_q.done  <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ===== inc/cmu_consts.svh
// constants of the capture/match unit
`ifndef CMU_CONSTS_SVH
`define CMU_CONSTS_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define CMU_TMR_W        16
`define CMU_NUM_CHAN     16
`define CMU_NUM_TMR      2
`define CMU_PRE_W        11

// ----------------------------------------------------------------------
// timing count and double mode channel offset
// ----------------------------------------------------------------------
`define CMU_STAGGER_CYC  8
`define CMU_DBL_OFFSET   8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CMU_RST_COUNT    16'h0000
`define CMU_RST_RELOAD   16'h0000
`define CMU_RST_VALUE    16'h0000
`define CMU_RST_PIN      1'b0
`define CMU_RST_OE_N     1'b1

`endif

// ===== inc/cmu_pkg.sv
// types of the capture/match unit
`include "cmu_consts.svh"

package cmu_pkg;

  // --------------------------------------------------------------------
  // channel and timer modes
  // --------------------------------------------------------------------
  typedef enum logic [6:0] {
    CMU_MODE_OFF  = 7'h01,
    CMU_MODE_CAP  = 7'h02,
    CMU_MODE_CMP0 = 7'h04,
    CMU_MODE_CMP1 = 7'h08,
    CMU_MODE_CMP2 = 7'h10,
    CMU_MODE_CMP3 = 7'h20,
    CMU_MODE_DBL  = 7'h40
  } cmu_mode_t;

  typedef enum logic [2:0] {
    CMU_EDGE_RISE = 3'h1,
    CMU_EDGE_FALL = 3'h2,
    CMU_EDGE_BOTH = 3'h4
  } cmu_edge_t;

  typedef enum logic [2:0] {
    CMU_CLK_PRESC = 3'h1,
    CMU_CLK_GPT   = 3'h2,
    CMU_CLK_EXT   = 3'h4
  } cmu_tclk_t;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    cmu_mode_t mode;
    cmu_edge_t edge_sel;
    logic      tmr_sel;
    logic      single_en;
  } cmu_chan_cfg_t;

  typedef struct packed {
    cmu_tclk_t  clk_sel;
    logic [2:0] presc;
    logic       run;
  } cmu_tmr_cfg_t;

  typedef struct packed {
    logic [`CMU_TMR_W-1:0] count;
    logic                  tick;
    logic                  ovf;
  } cmu_tmr_stat_t;

endpackage

// ===== verilog/cmu_edge.sv
// pin edge detector for capture triggers
`include "cmu_consts.svh"

module cmu_edge (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              pin_in,
  input  cmu_pkg::cmu_edge_t     sel_in,
  output logic                   trig_out
);

  typedef struct packed {
    logic prev;
  } cmu_edge_st_t;

  cmu_edge_st_t st_q;
  cmu_edge_st_t st_d;
  logic         rise;
  logic         fall;

  assign rise = pin_in & ~st_q.prev;
  assign fall = ~pin_in & st_q.prev;

  always_comb begin
    st_d      = st_q;
    st_d.prev = pin_in;
    case (sel_in)
      cmu_pkg::CMU_EDGE_RISE: trig_out = rise;
      cmu_pkg::CMU_EDGE_FALL: trig_out = fall;
      cmu_pkg::CMU_EDGE_BOTH: trig_out = rise | fall;
      default:                trig_out = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q.prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ===== verilog/cmu_timer.sv
// one reloadable time base with selectable count clock
`include "cmu_consts.svh"

module cmu_timer #(
  parameter int W = `CMU_TMR_W
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  cmu_pkg::cmu_tmr_cfg_t  cfg_in,
  input  wire logic              stagger_in,
  input  wire logic              gpt_ovf_in,
  input  wire logic              ext_cnt_in,
  input  wire logic              load_in,
  input  wire logic [W-1:0]      load_val_in,
  input  wire logic [W-1:0]      reload_val_in,
  output cmu_pkg::cmu_tmr_stat_t stat_out
);

  typedef struct packed {
    logic [`CMU_PRE_W-1:0] pre;
    logic [W-1:0]          count;
    logic                  tick;
    logic                  ovf;
    logic                  ext_prev;
  } cmu_tmr_st_t;

  cmu_tmr_st_t st_q;
  cmu_tmr_st_t st_d;
  logic        step;

  // --------------------------------------------------------------------
  // prescaler period: 2^presc cycles, or eight times that when staggered
  // --------------------------------------------------------------------
  function automatic logic [`CMU_PRE_W-1:0] pre_last(
    input logic [2:0] presc,
    input logic       stag
  );
    logic [`CMU_PRE_W-1:0] d;
    d = `CMU_PRE_W'(1) << presc;
    if (stag) begin
      d = d * `CMU_PRE_W'(`CMU_STAGGER_CYC);
    end
    return d - `CMU_PRE_W'(1);
  endfunction

  always_comb begin
    st_d          = st_q;
    st_d.tick     = 1'b0;
    st_d.ovf      = 1'b0;
    st_d.ext_prev = ext_cnt_in;
    step          = 1'b0;
    if (st_q.pre >= pre_last(cfg_in.presc, stagger_in)) begin
      st_d.pre = '0;
    end else begin
      st_d.pre = st_q.pre + `CMU_PRE_W'(1);
    end
    case (cfg_in.clk_sel)
      cmu_pkg::CMU_CLK_PRESC:
        step = st_q.pre >= pre_last(cfg_in.presc, stagger_in);
      cmu_pkg::CMU_CLK_GPT: step = gpt_ovf_in;
      cmu_pkg::CMU_CLK_EXT: step = ext_cnt_in & ~st_q.ext_prev;
      default:              step = 1'b0;
    endcase
    if (load_in) begin
      st_d.count = load_val_in;
      st_d.tick  = 1'b1;
    end else if (cfg_in.run && step) begin
      st_d.tick = 1'b1;
      if (&st_q.count) begin
        st_d.count = reload_val_in;
        st_d.ovf   = 1'b1;
      end else begin
        st_d.count = st_q.count + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q.pre      <= '0;
      st_q.count    <= `CMU_RST_COUNT;
      st_q.tick     <= 1'b0;
      st_q.ovf      <= 1'b0;
      st_q.ext_prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stat_out = '{count: st_q.count, tick: st_q.tick, ovf: st_q.ovf};

endmodule

// ===== dv/cmu_top_assertions.sv
// port assertions for the capture/match unit
module cmu_top_assertions #(
  parameter int W  = 16,
  parameter int NC = 16,
  parameter int NT = 2
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  cmu_pkg::cmu_tmr_cfg_t  tmr_cfg_in      [NT],
  input  wire logic [NT-1:0]     tmr_load_in,
  input  wire logic [W-1:0]      tmr_load_val_in [NT],
  input  wire logic              gpt_ovf_in,
  input  cmu_pkg::cmu_chan_cfg_t chan_cfg_in     [NC],
  input  wire logic [NC-1:0]     cc_wr_in,
  input  wire logic [NC-1:0]     pin_in,
  input  wire logic [NC-1:0]     pin_out,
  input  wire logic [NC-1:0]     pin_oe_n_out,
  input  wire logic [W-1:0]      cc_val_out      [NC],
  input  wire logic [NC-1:0]     irq_out,
  input  wire logic [NC-1:0]     done_out,
  input  wire logic [W-1:0]      tmr_count_out   [NT],
  input  wire logic [NT-1:0]     tmr_ovf_out,
  input  wire logic [W-1:0]      tmr_reload_out  [NT]
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic         pin1_q;
  logic         cap_hit;
  logic [W-1:0] cap_cnt;
  always_ff @(posedge core_clk_in) begin
    pin1_q <= pin_in[1];
  end
  assign cap_cnt = chan_cfg_in[1].tmr_sel ? tmr_count_out[1]
                                          : tmr_count_out[0];
  assign cap_hit = chan_cfg_in[1].mode == cmu_pkg::CMU_MODE_CAP &&
    (pin_in[1] && !pin1_q
       && chan_cfg_in[1].edge_sel != cmu_pkg::CMU_EDGE_FALL
     || !pin_in[1] && pin1_q
       && chan_cfg_in[1].edge_sel != cmu_pkg::CMU_EDGE_RISE);
  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  property p_ovf_reload;
    tmr_ovf_out[0] |-> tmr_count_out[0] == tmr_reload_out[0];
  endproperty
  a_ovf_reload: assert property (p_ovf_reload)
    else $error("overflow count differs from reload");
  property p_gpt_step;
    tmr_cfg_in[0].clk_sel == cmu_pkg::CMU_CLK_GPT && tmr_cfg_in[0].run &&
    gpt_ovf_in && !tmr_load_in[0] |=> tmr_ovf_out[0] ||
    tmr_count_out[0] == $past(tmr_count_out[0]) + 1'b1;
  endproperty
  a_gpt_step: assert property (p_gpt_step)
    else $error("timer missed a general timer step");
  property p_stop;
    !tmr_cfg_in[1].run && !tmr_load_in[1] |=> $stable(tmr_count_out[1]);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped timer moved");
  property p_load;
    tmr_load_in[0] |=> tmr_count_out[0] == $past(tmr_load_val_in[0]);
  endproperty
  a_load: assert property (p_load)
    else $error("timer load lost");
  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  property p_cap;
    cap_hit |=> irq_out[1] && cc_val_out[1] == $past(cap_cnt);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture value or request missing");
  property p_cap_none;
    chan_cfg_in[1].mode == cmu_pkg::CMU_MODE_CAP && !cap_hit |=> !irq_out[1];
  endproperty
  a_cap_none: assert property (p_cap_none)
    else $error("capture request without selected edge");
  property p_cmp1;
    irq_out[2] && $past(chan_cfg_in[2].mode) == cmu_pkg::CMU_MODE_CMP1
    |-> pin_out[2] != $past(pin_out[2]);
  endproperty
  a_cmp1: assert property (p_cmp1)
    else $error("toggle mode pin did not toggle");
  property p_cmp3_set;
    irq_out[3] && $past(chan_cfg_in[3].mode) == cmu_pkg::CMU_MODE_CMP3
    |-> pin_out[3];
  endproperty
  a_cmp3_set: assert property (p_cmp3_set)
    else $error("set mode pin not high on match");
  property p_cmp3_clr;
    chan_cfg_in[3].mode == cmu_pkg::CMU_MODE_CMP3 && !chan_cfg_in[3].tmr_sel
    && tmr_ovf_out[0] && cc_val_out[3] != tmr_count_out[0] |=> !pin_out[3];
  endproperty
  a_cmp3_clr: assert property (p_cmp3_clr)
    else $error("set mode pin not cleared on overflow");
  property p_dbl;
    irq_out[0] && $past(chan_cfg_in[0].mode) == cmu_pkg::CMU_MODE_DBL
    |-> pin_out[0] != $past(pin_out[0]);
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("double mode pin did not toggle");
  property p_single;
    done_out[5] && !cc_wr_in[5] |=> !irq_out[5];
  endproperty
  a_single: assert property (p_single)
    else $error("single event channel fired again");
  property p_oe;
    chan_cfg_in[1].mode == cmu_pkg::CMU_MODE_CAP |=> pin_oe_n_out[1];
  endproperty
  a_oe: assert property (p_oe)
    else $error("capture pin driven");
  c_cap: cover property (cap_hit);
  c_ovf: cover property (tmr_ovf_out[0]);
  c_done: cover property (done_out[5]);
endmodule

bind cmu_top cmu_top_assertions #(.W(W), .NC(NC), .NT(NT))
  u_cmu_top_assertions (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .tmr_cfg_in(tmr_cfg_in),
  .tmr_load_in(tmr_load_in), .tmr_load_val_in(tmr_load_val_in),
  .gpt_ovf_in(gpt_ovf_in), .chan_cfg_in(chan_cfg_in), .cc_wr_in(cc_wr_in),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
  .cc_val_out(cc_val_out), .irq_out(irq_out), .done_out(done_out),
  .tmr_count_out(tmr_count_out), .tmr_ovf_out(tmr_ovf_out),
  .tmr_reload_out(tmr_reload_out)
);

// ===== dv/cmu_pin_model.sv
// level model of the channel pins outside the unit
module cmu_pin_model (
  input  wire logic [15:0] pin_drv_in,
  input  wire logic [15:0] pin_oe_n_in,
  input  wire logic [15:0] ext_lvl_in,
  output logic      [15:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // a pin follows the unit while driven, else the outside source
  assign pin_level_out = (pin_drv_in & ~pin_oe_n_in) |
                         (ext_lvl_in & pin_oe_n_in);
endmodule

// ===== dv/cmu_top_tb.sv
// self-checking bench for the capture/match unit
module cmu_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                   core_clk_in, rst_in, stagger_in, gpt_ovf_in;
  cmu_pkg::cmu_tmr_cfg_t  tmr_cfg  [2];
  cmu_pkg::cmu_chan_cfg_t chan_cfg [16];
  logic [1:0]             tmr_load, rl_wr, ext_cnt, tmr_ovf;
  logic [15:0]            ld_val [2], rl_val [2], cnt [2], rl_o [2];
  logic [15:0]            wdata [16], cc_val [16];
  logic [15:0]            cc_wr, pin_in, pin_out, oe_n, irq, done, ext_lvl;
  logic [15:0]            cnt_s, a;
  logic                   ovf_s;
  int                     bad_count, total_checks;
  logic        t_ld  [8] = '{0, 0, 0, 1, 1, 0, 1, 1};
  logic [15:0] t_v   [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0011,
                             16'hFFFF, 16'h0000, 16'h0011, 16'h0011};
  logic [15:0] t_irq [8] = '{16'h0039, 16'h0004, 16'h0101, 16'h0001,
                             16'h0000, 16'h0000, 16'h0019, 16'h0021};
  logic [15:0] t_pin [8] = '{16'h0009, 16'h000D, 16'h000C, 16'h000D,
                             16'h000D, 16'h0005, 16'h000C, 16'h000D};
  cmu_top u_cmu_top (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .stagger_in(stagger_in),
    .tmr_cfg_in(tmr_cfg), .tmr_load_in(tmr_load), .tmr_load_val_in(ld_val),
    .tmr_reload_wr_in(rl_wr), .tmr_reload_val_in(rl_val),
    .gpt_ovf_in(gpt_ovf_in), .ext_cnt_in(ext_cnt), .chan_cfg_in(chan_cfg),
    .cc_wr_in(cc_wr), .cc_wdata_in(wdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(oe_n), .cc_val_out(cc_val),
    .irq_out(irq), .done_out(done), .tmr_count_out(cnt),
    .tmr_ovf_out(tmr_ovf), .tmr_reload_out(rl_o)
  );
  cmu_pin_model u_cmu_pin_model (
    .pin_drv_in(pin_out), .pin_oe_n_in(oe_n), .ext_lvl_in(ext_lvl),
    .pin_level_out(pin_in)
  );
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // one timer 0 step (general timer pulse or load), then the match cycle
  task automatic tick(input logic ld, input logic [15:0] v);
    gpt_ovf_in = !ld;
    tmr_load[0] = ld;
    ld_val[0] = v;
    cyc(1);
    gpt_ovf_in = 1'b0;
    tmr_load[0] = 1'b0;
    cnt_s = cnt[0];
    ovf_s = tmr_ovf[0];
    cyc(1);
  endtask
  function automatic cmu_pkg::cmu_chan_cfg_t cc(
      input cmu_pkg::cmu_mode_t m, input logic s);
    return '{m, cmu_pkg::CMU_EDGE_RISE, 1'b0, s};
  endfunction
  // ----------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (2000) @(posedge core_clk_in);
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_in = 1'b1;
    stagger_in = 1'b0;
    gpt_ovf_in = 1'b0;
    tmr_load = 2'h0;
    rl_wr = 2'h0;
    ext_cnt = 2'h0;
    cc_wr = 16'h0000;
    ext_lvl = 16'h0000;
    ld_val = '{16'h0000, 16'h0000};
    rl_val = '{16'h0000, 16'h0000};
    tmr_cfg[0] = '{cmu_pkg::CMU_CLK_GPT, 3'h0, 1'b1};
    tmr_cfg[1] = '{cmu_pkg::CMU_CLK_PRESC, 3'h2, 1'b1};
    foreach (chan_cfg[i]) begin
      chan_cfg[i] = cc(cmu_pkg::CMU_MODE_OFF, 1'b0);
      wdata[i] = 16'h0000;
    end
    cyc(6);
    rst_in = 1'b0;
    check("count", cnt[0], 16'h0000);
    check("oe_n", oe_n, 16'hFFFF);
    rl_wr[0] = 1'b1;
    rl_val[0] = 16'h0010;
    cyc(1);
    rl_wr[0] = 1'b0;
    check("reload", rl_o[0], 16'h0010);
    chan_cfg[0] = cc(cmu_pkg::CMU_MODE_DBL, 1'b0);
    chan_cfg[2] = cc(cmu_pkg::CMU_MODE_CMP1, 1'b0);
    chan_cfg[3] = cc(cmu_pkg::CMU_MODE_CMP3, 1'b0);
    chan_cfg[4] = cc(cmu_pkg::CMU_MODE_CMP2, 1'b0);
    chan_cfg[5] = cc(cmu_pkg::CMU_MODE_CMP0, 1'b1);
    chan_cfg[8] = cc(cmu_pkg::CMU_MODE_CMP0, 1'b0);
    wdata = '{16'h0011, 16'h0000, 16'h0012, 16'h0011, 16'h0011, 16'h0011,
              16'h0000, 16'h0000, 16'h0013, 16'h0000, 16'h0000, 16'h0000,
              16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cc_wr = 16'h013D;
    cyc(1);
    cc_wr = 16'h0000;
    tick(1'b1, 16'h0010);
    check("oe_n", oe_n, 16'hFFF2);
    check("irq", irq, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) begin
        check("done", done, 16'h0020);
        cc_wr = 16'h0020;
        cyc(1);
        cc_wr = 16'h0000;
        check("done", done, 16'h0000);
      end
      tick(t_ld[i], t_v[i]);
      check("irq", irq, t_irq[i]);
      check("pin", pin_out & 16'h000D, t_pin[i]);
      if (i == 5) begin
        check("ovf", ovf_s, 16'h0001);
        check("wrap", cnt_s, 16'h0010);
      end
    end
    foreach (chan_cfg[i]) chan_cfg[i] = cc(cmu_pkg::CMU_MODE_OFF, 1'b0);
    chan_cfg[1] = cc(cmu_pkg::CMU_MODE_CAP, 1'b0);
    for (int e = 0; e < 3; e++) begin
      chan_cfg[1].edge_sel = cmu_pkg::cmu_edge_t'(3'h1 << e);
      tick(1'b1, 16'h1230 + 16'(e));
      ext_lvl[1] = 1'b1;
      cyc(1);
      check("cap_rise", irq, {14'h0000, e != 1, 1'b0});
      ext_lvl[1] = 1'b0;
      cyc(1);
      check("cap_fall", irq, {14'h0000, e != 0, 1'b0});
      check("cap_val", cc_val[1], 16'h1230 + 16'(e));
    end
    a = cnt[1];
    cyc(16);
    check("presc", cnt[1] - a, 16'h0004);
    stagger_in = 1'b1;
    cyc(40);
    a = cnt[1];
    cyc(64);
    check("stagger", cnt[1] - a, 16'h0002);
    tmr_cfg[1] = '{cmu_pkg::CMU_CLK_EXT, 3'h0, 1'b1};
    cyc(2);
    a = cnt[1];
    repeat (3) begin
      ext_cnt[1] = 1'b1;
      cyc(2);
      ext_cnt[1] = 1'b0;
      cyc(2);
    end
    check("ext", cnt[1] - a, 16'h0003);
    tmr_cfg[1].run = 1'b0;
    a = cnt[1];
    ext_cnt[1] = 1'b1;
    cyc(3);
    check("stopped", cnt[1], a);
    chan_cfg[1].tmr_sel = 1'b1;
    ext_lvl[1] = 1'b1;
    cyc(1);
    check("cap_tmr1", cc_val[1], a);
    end_of_test();
  end
endmodule
